// file: logic/dolc_params.svh
// Constants for the demodulator offset loop configuration block.
// Assumes inclusion by bare name from files under logic/.
`ifndef DOLC_PARAMS_SVH
`define DOLC_PARAMS_SVH

// Register addresses
`define DOLC_ADDR_FREQ      8'h19
`define DOLC_ADDR_BSYNC     8'h1A
`define DOLC_ADDR_STATUS    8'h30

// Reset values and write mask
`define DOLC_FREQ_RESET     8'h36
`define DOLC_BSYNC_RESET    8'h6C
`define DOLC_FREQ_WR_MASK   8'h3F

// Frequency configuration fields
`define DOLC_F_GATE_BIT     5
`define DOLC_F_PREK_HI      4
`define DOLC_F_PREK_LO      3
`define DOLC_F_POSTK_BIT    2
`define DOLC_F_LIMIT_HI     1
`define DOLC_F_LIMIT_LO     0

// Clock recovery configuration fields
`define DOLC_B_PREKI_HI     7
`define DOLC_B_PREKI_LO     6
`define DOLC_B_PREKP_HI     5
`define DOLC_B_PREKP_LO     4
`define DOLC_B_POSTKI_BIT   3
`define DOLC_B_POSTKP_BIT   2
`define DOLC_B_LIMIT_HI     1
`define DOLC_B_LIMIT_LO     0

// Status fields
`define DOLC_S_LOCKED_BIT   0
`define DOLC_S_FROZEN_BIT   1
`define DOLC_S_FSAT_BIT     2
`define DOLC_S_RSAT_BIT     3

// Gains in half-unit steps: one unit reads as 4'h2
`define DOLC_GAIN_HALF      4'h1
`define DOLC_GAIN_UNIT      4'h2

// Saturation shifts: bandwidth/8,/4,/2 and rate 3.125,6.25,12.5 percent
`define DOLC_FSHIFT_1       3
`define DOLC_FSHIFT_2       2
`define DOLC_FSHIFT_3       1
`define DOLC_RSHIFT_1       5
`define DOLC_RSHIFT_2       4
`define DOLC_RSHIFT_3       3

`endif

// file: logic/dolc_pkg.sv
// Types for the demodulator offset loop configuration block.
// Assumes nothing of its surroundings.
package dolc_pkg;

	typedef enum logic [1:0] {
		DOLC_SEARCH = 2'h0,
		DOLC_LOCKED = 2'h1
	} dolc_state_e;

	typedef logic [3:0] dolc_gain_t;
	typedef logic [1:0] dolc_limit_t;

endpackage

// file: logic/dolc_sat_if.sv
// Carrier between the control core and the saturation unit.
// Assumes both ends run combinationally on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface dolc_sat_if #(parameter int W = 16);
	logic [1:0]          freq_limit;
	logic [1:0]          rate_limit;
	logic signed [W-1:0] freq_in;
	logic signed [W-1:0] rate_in;
	logic [W-1:0]        channel_bandwidth;
	logic [W-1:0]        nominal_rate;
	logic signed [W-1:0] freq_out;
	logic signed [W-1:0] rate_out;
	logic                freq_sat;
	logic                rate_sat;

	modport core (output freq_limit, rate_limit, freq_in, rate_in, channel_bandwidth, nominal_rate,
		input freq_out, rate_out, freq_sat, rate_sat);
	modport sat (input freq_limit, rate_limit, freq_in, rate_in, channel_bandwidth, nominal_rate,
		output freq_out, rate_out, freq_sat, rate_sat);
endinterface
`default_nettype wire

// file: logic/dolc_sat_unit.sv
// Saturation of frequency and data rate offset corrections.
// Assumes unsigned bandwidth and rate, signed offsets; purely combinational.
`timescale 1ns/1ps
`default_nettype none
module dolc_sat_unit #(
	parameter int W = 16
) (
	// Loop side
	dolc_sat_if.sat sif
);
	import dolc_pkg::*;
	`include "dolc_params.svh"

	function automatic logic [W-1:0] limit_of(input logic [W-1:0] base, input dolc_limit_t code,
		input int s1, input int s2, input int s3);
		logic [W-1:0] r;
		r = '0;
		if (code == 2'h1) begin
			r = base >> s1;
		end else if (code == 2'h2) begin
			r = base >> s2;
		end else if (code == 2'h3) begin
			r = base >> s3;
		end
		return r;
	endfunction

	// Limit is at least one shift down, so it always fits as a positive value
	function automatic logic signed [W-1:0] clamp(input logic signed [W-1:0] v, input logic [W-1:0] lim);
		logic signed [W:0] vx;
		logic signed [W:0] lx;
		logic signed [W:0] nx;
		logic signed [W-1:0] r;
		vx = {v[W-1], v};
		lx = $signed({1'b0, lim});
		nx = -lx;
		r  = v;
		if (vx > lx) begin
			r = $signed(lim);
		end else if (vx < nx) begin
			r = nx[W-1:0];
		end
		return r;
	endfunction

	logic [W-1:0] freq_lim;
	logic [W-1:0] rate_lim;

	always_comb begin
		freq_lim     = limit_of(sif.channel_bandwidth, sif.freq_limit,
			`DOLC_FSHIFT_1, `DOLC_FSHIFT_2, `DOLC_FSHIFT_3);
		rate_lim     = limit_of(sif.nominal_rate, sif.rate_limit,
			`DOLC_RSHIFT_1, `DOLC_RSHIFT_2, `DOLC_RSHIFT_3);
		sif.freq_out = clamp(sif.freq_in, freq_lim);
		sif.rate_out = clamp(sif.rate_in, rate_lim);
		sif.freq_sat = (sif.freq_out != sif.freq_in);
		sif.rate_sat = (sif.rate_out != sif.rate_in);
	end
endmodule
`default_nettype wire

// file: logic/dolc_top.sv
// Control core of the frequency offset and clock recovery loop configuration.
// Assumes datapath inputs on ref_clk and a host port on the same clock.
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module dolc_top
	import dolc_pkg::*;
#(
	parameter int W = 16
) (
	// Clock and reset
	input  wire logic                ref_clk,
	input  wire logic                rst,
	// Register port
	input  wire logic [7:0]          reg_addr,
	input  wire logic [7:0]          reg_wdata,
	input  wire logic                reg_wr,
	input  wire logic                reg_rd,
	output var  logic [7:0]          reg_rdata,
	// Demodulator datapath
	input  wire logic                rx_start,
	input  wire logic                sync_detected,
	input  wire logic                carrier_sense,
	input  wire logic                loop_update,
	input  wire logic signed [W-1:0] freq_offset_est,
	input  wire logic signed [W-1:0] rate_offset_est,
	input  wire logic [W-1:0]        channel_bandwidth,
	input  wire logic [W-1:0]        nominal_rate,
	// Loop controls
	output var  logic [3:0]          freq_gain,
	output var  logic [3:0]          clkrec_integral_gain,
	output var  logic [3:0]          clkrec_proportional_gain,
	output var  logic signed [W-1:0] freq_correction,
	output var  logic signed [W-1:0] rate_correction,
	output var  logic                freq_comp_enable,
	output var  logic                rate_comp_enable,
	output var  logic                loops_frozen,
	output var  logic                post_sync
);
	`include "dolc_params.svh"

	////////////////////////////////////////////////////////////////////////
	// Helpers

	// Pre-sync code n selects (n+1) units, in half-unit steps
	function automatic dolc_gain_t pre_gain(input dolc_limit_t code);
		dolc_gain_t g;
		g = {1'b0, code, 1'b0} + `DOLC_GAIN_UNIT;
		return g;
	endfunction

	function automatic dolc_gain_t pick_gain(input logic locked, input logic post_bit,
		input dolc_gain_t pre, input dolc_gain_t post);
		dolc_gain_t g;
		g = pre;
		if (locked && post_bit) begin
			g = post;
		end
		return g;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Configuration registers

	logic [7:0] freq_cfg_ff;
	logic [7:0] nxt_freq_cfg;
	logic [7:0] bsync_cfg_ff;
	logic [7:0] nxt_bsync_cfg;
	logic [7:0] rdata_ff;
	logic [7:0] nxt_rdata;
	logic [7:0] status_word;

	always_comb begin
		nxt_freq_cfg  = freq_cfg_ff;
		nxt_bsync_cfg = bsync_cfg_ff;
		if (reg_wr) begin
			if (reg_addr == `DOLC_ADDR_FREQ) begin
				nxt_freq_cfg = reg_wdata & `DOLC_FREQ_WR_MASK;
			end else if (reg_addr == `DOLC_ADDR_BSYNC) begin
				nxt_bsync_cfg = reg_wdata;
			end
		end
	end

	always_comb begin
		nxt_rdata = 8'h00;
		if (reg_rd) begin
			if (reg_addr == `DOLC_ADDR_FREQ) begin
				nxt_rdata = freq_cfg_ff & `DOLC_FREQ_WR_MASK;
			end else if (reg_addr == `DOLC_ADDR_BSYNC) begin
				nxt_rdata = bsync_cfg_ff;
			end else if (reg_addr == `DOLC_ADDR_STATUS) begin
				nxt_rdata = status_word;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			freq_cfg_ff  <= `DOLC_FREQ_RESET;
			bsync_cfg_ff <= `DOLC_BSYNC_RESET;
			rdata_ff     <= 8'h00;
		end else begin
			freq_cfg_ff  <= nxt_freq_cfg;
			bsync_cfg_ff <= nxt_bsync_cfg;
			rdata_ff     <= nxt_rdata;
		end
	end

	assign reg_rdata = rdata_ff;

	////////////////////////////////////////////////////////////////////////
	// Field views

	logic        cs_gate;
	dolc_limit_t f_prek;
	logic        f_postk;
	dolc_limit_t f_limit;
	dolc_limit_t b_preki;
	dolc_limit_t b_prekp;
	logic        b_postki;
	logic        b_postkp;
	dolc_limit_t b_limit;

	always_comb begin
		cs_gate  = freq_cfg_ff[`DOLC_F_GATE_BIT];
		f_prek   = freq_cfg_ff[`DOLC_F_PREK_HI:`DOLC_F_PREK_LO];
		f_postk  = freq_cfg_ff[`DOLC_F_POSTK_BIT];
		f_limit  = freq_cfg_ff[`DOLC_F_LIMIT_HI:`DOLC_F_LIMIT_LO];
		b_preki  = bsync_cfg_ff[`DOLC_B_PREKI_HI:`DOLC_B_PREKI_LO];
		b_prekp  = bsync_cfg_ff[`DOLC_B_PREKP_HI:`DOLC_B_PREKP_LO];
		b_postki = bsync_cfg_ff[`DOLC_B_POSTKI_BIT];
		b_postkp = bsync_cfg_ff[`DOLC_B_POSTKP_BIT];
		b_limit  = bsync_cfg_ff[`DOLC_B_LIMIT_HI:`DOLC_B_LIMIT_LO];
	end

	////////////////////////////////////////////////////////////////////////
	// Reception phase

	dolc_state_e state_ff;
	dolc_state_e nxt_state;

	// A new reception wins over a sync hit in the same cycle
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			DOLC_SEARCH: begin
				if (!rx_start && sync_detected) begin
					nxt_state = DOLC_LOCKED;
				end
			end
			DOLC_LOCKED: begin
				if (rx_start) begin
					nxt_state = DOLC_SEARCH;
				end
			end
			default: begin
				nxt_state = DOLC_SEARCH;
			end
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_ff <= DOLC_SEARCH;
		end else begin
			state_ff <= nxt_state;
		end
	end

	logic locked;
	assign locked = (state_ff == DOLC_LOCKED);

	////////////////////////////////////////////////////////////////////////
	// Freeze until carrier

	logic frozen_ff;
	logic nxt_frozen;

	// Level view; carrier sense comes from the datapath on this clock
	always_comb begin
		nxt_frozen = cs_gate && !carrier_sense;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			frozen_ff <= 1'b1;
		end else begin
			frozen_ff <= nxt_frozen;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Saturation unit

	dolc_sat_if #(.W(W)) sif ();

	always_comb begin
		sif.freq_limit        = f_limit;
		sif.rate_limit        = b_limit;
		sif.freq_in           = freq_offset_est;
		sif.rate_in           = rate_offset_est;
		sif.channel_bandwidth = channel_bandwidth;
		sif.nominal_rate      = nominal_rate;
	end

	dolc_sat_unit #(.W(W)) u_sat (
		.sif (sif.sat)
	);

	////////////////////////////////////////////////////////////////////////
	// Loop outputs

	dolc_gain_t          fgain_ff;
	dolc_gain_t          nxt_fgain;
	dolc_gain_t          kigain_ff;
	dolc_gain_t          nxt_kigain;
	dolc_gain_t          kpgain_ff;
	dolc_gain_t          nxt_kpgain;
	logic signed [W-1:0] fcorr_ff;
	logic signed [W-1:0] nxt_fcorr;
	logic signed [W-1:0] rcorr_ff;
	logic signed [W-1:0] nxt_rcorr;
	logic                fen_ff;
	logic                nxt_fen;
	logic                ren_ff;
	logic                nxt_ren;
	logic                fsat_ff;
	logic                nxt_fsat;
	logic                rsat_ff;
	logic                nxt_rsat;
	logic                lock_out_ff;
	logic                nxt_lock_out;
	logic                advance;

	// Frozen loops hold every correction and gain as they stand
	assign advance = loop_update && !nxt_frozen;

	always_comb begin
		nxt_fgain    = fgain_ff;
		nxt_kigain   = kigain_ff;
		nxt_kpgain   = kpgain_ff;
		nxt_fcorr    = fcorr_ff;
		nxt_rcorr    = rcorr_ff;
		nxt_fen      = fen_ff;
		nxt_ren      = ren_ff;
		nxt_fsat     = fsat_ff;
		nxt_rsat     = rsat_ff;
		nxt_lock_out = locked;
		// Sampled only on a loop update so a mid-update write cannot tear a step
		if (advance) begin
			nxt_fgain  = pick_gain(locked, f_postk, pre_gain(f_prek), `DOLC_GAIN_HALF);
			nxt_kigain = pick_gain(locked, b_postki, pre_gain(b_preki), `DOLC_GAIN_HALF);
			nxt_kpgain = pick_gain(locked, b_postkp, pre_gain(b_prekp), `DOLC_GAIN_UNIT);
			nxt_fcorr  = sif.freq_out;
			nxt_rcorr  = sif.rate_out;
			nxt_fen    = (f_limit != 2'h0);
			nxt_ren    = (b_limit != 2'h0);
			nxt_fsat   = sif.freq_sat;
			nxt_rsat   = sif.rate_sat;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			fgain_ff    <= 4'h6;
			kigain_ff   <= 4'h4;
			kpgain_ff   <= 4'h6;
			fcorr_ff    <= '0;
			rcorr_ff    <= '0;
			fen_ff      <= 1'b1;
			ren_ff      <= 1'b0;
			fsat_ff     <= 1'b0;
			rsat_ff     <= 1'b0;
			lock_out_ff <= 1'b0;
		end else begin
			fgain_ff    <= nxt_fgain;
			kigain_ff   <= nxt_kigain;
			kpgain_ff   <= nxt_kpgain;
			fcorr_ff    <= nxt_fcorr;
			rcorr_ff    <= nxt_rcorr;
			fen_ff      <= nxt_fen;
			ren_ff      <= nxt_ren;
			fsat_ff     <= nxt_fsat;
			rsat_ff     <= nxt_rsat;
			lock_out_ff <= nxt_lock_out;
		end
	end

	always_comb begin
		status_word = 8'h00;
		status_word[`DOLC_S_LOCKED_BIT] = locked;
		status_word[`DOLC_S_FROZEN_BIT] = frozen_ff;
		status_word[`DOLC_S_FSAT_BIT]   = fsat_ff;
		status_word[`DOLC_S_RSAT_BIT]   = rsat_ff;
	end

	assign freq_gain                = fgain_ff;
	assign clkrec_integral_gain     = kigain_ff;
	assign clkrec_proportional_gain = kpgain_ff;
	assign freq_correction          = fcorr_ff;
	assign rate_correction          = rcorr_ff;
	assign freq_comp_enable         = fen_ff;
	assign rate_comp_enable         = ren_ff;
	assign loops_frozen             = frozen_ff;
	assign post_sync                = lock_out_ff;

endmodule
`default_nettype wire

// file: bench/dolc_asserts.sv
// Port checker for dolc_top.
// Assumes one clock; config is shadowed from host writes.
`timescale 1ns/1ps
`default_nettype none
module dolc_asserts
	import dolc_pkg::*;
#(
	parameter int W = 16
) (
	// Clock and reset
	input wire logic                ref_clk,
	input wire logic                rst,
	// Register port
	input wire logic [7:0]          reg_addr,
	input wire logic [7:0]          reg_wdata,
	input wire logic                reg_wr,
	input wire logic                reg_rd,
	input wire logic [7:0]          reg_rdata,
	// Datapath and loop controls
	input wire logic                rx_start,
	input wire logic                sync_detected,
	input wire logic                carrier_sense,
	input wire logic                loop_update,
	input wire logic [3:0]          freq_gain,
	input wire logic signed [W-1:0] freq_correction,
	input wire logic                freq_comp_enable,
	input wire logic                loops_frozen,
	input wire logic                post_sync
);
	logic [7:0] f_ff;
	logic [7:0] nxt_f;
	logic       lk_ff;
	logic       nxt_lk;
	logic       take;
	logic [3:0] exp_g;

	always_comb begin
		nxt_f = f_ff;
		if (reg_wr && reg_addr == 8'h19) begin
			nxt_f = reg_wdata & 8'h3F;
		end
		nxt_lk = rx_start ? 1'b0 : (sync_detected ? 1'b1 : lk_ff);
		take = loop_update && !(f_ff[5] && !carrier_sense);
		exp_g = (lk_ff && f_ff[2]) ? 4'h1 : {1'b0, f_ff[4:3], 1'b0} + 4'h2;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			f_ff <= 8'h36;
			lk_ff <= 1'b0;
		end else begin
			f_ff <= nxt_f;
			lk_ff <= nxt_lk;
		end
	end

	////////////////////////////////////////////////////////////////
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);

	a_frozen_level: assert property (1 |=> loops_frozen == $past(f_ff[5] && !carrier_sense))
		else $error("frozen flag mismatch");
	a_frozen_hold: assert property (loop_update && f_ff[5] && !carrier_sense |=>
		$stable(freq_gain) && $stable(freq_correction)) else $error("frozen loop moved");
	a_freq_gain: assert property (take |=> freq_gain == $past(exp_g))
		else $error("freq gain mismatch");
	a_freq_off: assert property (take && f_ff[1:0] == 2'h0 |=>
		freq_correction == '0 && !freq_comp_enable) else $error("freq comp not off");
	a_post_sync: assert property (sync_detected && !rx_start |-> ##2 post_sync)
		else $error("post sync late");
	a_rx_restart: assert property (rx_start |-> ##2 !post_sync)
		else $error("rx start kept post sync");
	a_read_cfg: assert property (reg_rd && reg_addr == 8'h19 |=> reg_rdata == $past(f_ff))
		else $error("freq cfg read mismatch");
	a_read_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data not cleared");
	a_read_unmapped: assert property (reg_rd && !(reg_addr inside {8'h19, 8'h1A, 8'h30}) |=>
		reg_rdata == 8'h00) else $error("unmapped read not zero");
endmodule

bind dolc_top dolc_asserts #(.W(W)) u_chk (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata, .rx_start, .sync_detected, .carrier_sense, .loop_update, .freq_gain,
	.freq_correction, .freq_comp_enable, .loops_frozen, .post_sync);
`default_nettype wire

// file: bench/testbench.sv
// Self-checking bench for dolc_top.
// Assumes the port checker is bound from its own file.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_fail++; \
	$display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module testbench;
	import dolc_pkg::*;
	localparam int W = 16;
	int                     n_fail = 0;
	int                     n_compared = 0;
	logic                   ref_clk = 1'b0;
	logic                   rst = 1'b1;
	logic [7:0]             reg_addr = 8'h00;
	logic [7:0]             reg_wdata = 8'h00;
	logic                   reg_wr = 1'b0;
	logic                   reg_rd = 1'b0;
	logic [7:0]             reg_rdata;
	logic                   rx_start = 1'b0;
	logic                   sync_detected = 1'b0;
	logic                   carrier_sense = 1'b0;
	logic                   loop_update = 1'b0;
	logic signed [W-1:0]    freq_offset_est = '0;
	logic signed [W-1:0]    rate_offset_est = '0;
	logic [W-1:0]           channel_bandwidth = 16'h0800;
	logic [W-1:0]           nominal_rate = 16'h1000;
	logic [3:0]             freq_gain;
	logic [3:0]             clkrec_integral_gain;
	logic [3:0]             clkrec_proportional_gain;
	logic signed [W-1:0]    freq_correction;
	logic signed [W-1:0]    rate_correction;
	logic                   freq_comp_enable;
	logic                   rate_comp_enable;
	logic                   loops_frozen;
	logic                   post_sync;
	logic signed [W-1:0]    ev [3] = '{16'sh7000, -16'sh7000, 16'sh0005};

	dolc_top #(.W(W)) dut (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.rx_start, .sync_detected, .carrier_sense, .loop_update, .freq_offset_est, .rate_offset_est,
		.channel_bandwidth, .nominal_rate, .freq_gain, .clkrec_integral_gain, .clkrec_proportional_gain,
		.freq_correction, .rate_correction, .freq_comp_enable, .rate_comp_enable, .loops_frozen, .post_sync);

	always #2.5 ref_clk = ~ref_clk;

	////////////////////////////////////////////////////////////////
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		`CHK(reg_rdata, e)
	endtask

	// k: 0 loop update, 1 sync detect, 2 reception start
	task automatic pls(input int k);
		@(posedge ref_clk);
		{rx_start, sync_detected, loop_update} <= 3'b001 << k;
		@(posedge ref_clk);
		{rx_start, sync_detected, loop_update} <= 3'b000;
		#1;
	endtask

	function automatic logic signed [W-1:0] clp(input logic signed [W-1:0] e, input logic signed [W-1:0] l);
		return (e > l) ? l : ((e < -l) ? -l : e);
	endfunction

	task automatic end_sim;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	task automatic t_regs;
		`CHK(freq_gain, 4'h6)
		`CHK(loops_frozen, 1'b1)
		rdc(8'h19, 8'h36);
		rdc(8'h1A, 8'h6C);
		wr(8'h19, 8'hFF);
		rdc(8'h19, 8'h3F);
		wr(8'h1A, 8'hA5);
		rdc(8'h1A, 8'hA5);
		wr(8'h42, 8'hFF);
		rdc(8'h42, 8'h00);
		// Status is read only: the write must not disturb it
		wr(8'h30, 8'hFF);
		rdc(8'h30, 8'h02);
		$display("test regs done");
	endtask

	task automatic t_gate;
		wr(8'h19, 8'h3E);
		pls(0);
		`CHK(freq_gain, 4'h6)
		`CHK(loops_frozen, 1'b1)
		@(posedge ref_clk);
		carrier_sense <= 1'b1;
		pls(0);
		`CHK(loops_frozen, 1'b0)
		`CHK(freq_gain, 4'h8)
		$display("test gate done");
	endtask

	task automatic t_gains;
		for (int c = 0; c < 4; c++) begin
			wr(8'h19, 8'(c * 8 + 4));
			wr(8'h1A, 8'(c * 80 + 12));
			pls(0);
			`CHK(freq_gain, 4'(2 * c + 2))
			`CHK(clkrec_integral_gain, 4'(2 * c + 2))
			`CHK(clkrec_proportional_gain, 4'(2 * c + 2))
		end
		// Post-sync flag trails the phase by one cycle; look after the next update
		pls(1);
		pls(0);
		`CHK(post_sync, 1'b1)
		`CHK(freq_gain, 4'h1)
		`CHK(clkrec_integral_gain, 4'h1)
		`CHK(clkrec_proportional_gain, 4'h2)
		rdc(8'h30, 8'h01);
		wr(8'h19, 8'h18);
		wr(8'h1A, 8'hF0);
		pls(0);
		`CHK(freq_gain, 4'h8)
		`CHK(clkrec_integral_gain, 4'h8)
		`CHK(clkrec_proportional_gain, 4'h8)
		pls(2);
		wr(8'h19, 8'h1C);
		pls(0);
		`CHK(post_sync, 1'b0)
		`CHK(freq_gain, 4'h8)
		$display("test gains done");
	endtask

	task automatic t_clamp;
		logic signed [W-1:0] fl;
		logic signed [W-1:0] rl;
		for (int c = 0; c < 4; c++) begin
			// Limit code 0 is the setting software uses for on-off keying
			wr(8'h19, 8'(c));
			wr(8'h1A, 8'(c));
			fl = (c == 0) ? '0 : W'(channel_bandwidth >> (4 - c));
			rl = (c == 0) ? '0 : W'(nominal_rate >> (6 - c));
			for (int i = 0; i < 3; i++) begin
				@(posedge ref_clk);
				freq_offset_est <= ev[i];
				rate_offset_est <= -ev[i];
				pls(0);
				`CHK(freq_correction, clp(ev[i], fl))
				`CHK(rate_correction, clp(-ev[i], rl))
				`CHK(freq_comp_enable, 1'(c != 0))
				`CHK(rate_comp_enable, 1'(c != 0))
				rdc(8'h30, (clp(ev[i], fl) != ev[i]) ? 8'h0C : 8'h00);
			end
		end
		$display("test clamp done");
	endtask

	initial begin
		#200000;
		n_fail++;
		end_sim();
	end

	initial begin
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		#1;
		t_regs();
		t_gate();
		t_gains();
		t_clamp();
		end_sim();
	end
endmodule
`default_nettype wire
